// *** core/dvsg_gain.sv ***
// One attenuator stage: scales a sample by a 0.375 dB step count.
// Assumes steps of at most 191; every 16 steps is one binary shift.
`default_nettype none
module dvsg_gain #(
    parameter int W = 24
) (
    input wire logic signed [W-1:0] sample_i,
    input wire logic [7:0] atten_i,
    input wire logic mute_i,
    output logic signed [W-1:0] sample_o
);
    // ****************************************************************
    // Fractional step table, unity at 0x8000
    // ****************************************************************
    function automatic logic [16:0] mant_f(input logic [3:0] k);
        case (k)
            4'h0: mant_f = 17'h08000;
            4'h1: mant_f = 17'h07A98;
            4'h2: mant_f = 17'h0756A;
            4'h3: mant_f = 17'h07073;
            4'h4: mant_f = 17'h06BB3;
            4'h5: mant_f = 17'h06726;
            4'h6: mant_f = 17'h062CA;
            4'h7: mant_f = 17'h05E9E;
            4'h8: mant_f = 17'h05A9E;
            4'h9: mant_f = 17'h056CA;
            4'hA: mant_f = 17'h0531F;
            4'hB: mant_f = 17'h04F9C;
            4'hC: mant_f = 17'h04C3F;
            4'hD: mant_f = 17'h04906;
            4'hE: mant_f = 17'h045F0;
            default: mant_f = 17'h042FC;
        endcase
    endfunction

    logic signed [W+16:0] prod;
    logic signed [W+16:0] shifted;
    logic [4:0] shamt;

    // Shift by whole 6 dB octaves; truncation biases slightly negative
    always_comb begin
        prod = sample_i * $signed(mant_f(atten_i[3:0]));
        shamt = 5'hF + {1'b0, atten_i[7:4]};
        shifted = prod >>> shamt;
        sample_o = mute_i ? '0 : shifted[W-1:0];
    end
endmodule
`default_nettype wire

// *** core/dvsg_pkg.sv ***
// Constants for the playback gain and sidetone block.
// Assumes a word-wide classic Wishbone slave; index = byte address / 4.
//
// What this block does
// R01: Sidetone code 0 is -36 dB, +3 dB per step; codes 12-15 are 0 dB.
// R02: Left and right playback enables at power bits 4 and 5, reset zero.
// R03: Each enable also appears as bit 15 of that channel's gain register.
// R04: New gain values wait until a one is written to bit 8 of either.
// R05: Gain code zero mutes the channel's playback samples; its sidetone still passes.
// R06: Left gain code 1 is -71.625 dB, 0.375 dB steps, 0xC0 is 0 dB.
// R07: Right channel uses the same coding and reset, from its own register.
// R08: The playback path works at any sample rate from 8 to 48 kHz.
// R09: Sidetone samples come from the ADC high-pass output, then get scaled.
// R10: Gain codes above 0xC0 act as 0 dB, never amplifying.
`default_nettype none
package dvsg_pkg;
    // ****************************************************************
    // Register indices
    // ****************************************************************
    localparam logic [7:0] IDX_POWER = 8'h0B;
    localparam logic [7:0] IDX_GAIN_L = 8'h32;
    localparam logic [7:0] IDX_GAIN_R = 8'h33;
    localparam logic [7:0] IDX_SIDE_MIX = 8'h3C;
    localparam logic [7:0] IDX_SIDE_GAIN = 8'h44;
    localparam logic [7:0] IDX_STATUS = 8'h01;
    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int BIT_EN_L = 4;
    localparam int BIT_EN_R = 5;
    localparam int BIT_GAIN_EN = 15;
    localparam int BIT_UPDATE = 8;
    localparam int LSB_SIDE_L = 8;
    localparam int LSB_SIDE_R = 4;
    localparam int LSB_MIX_L = 12;
    localparam int LSB_MIX_R = 10;
    localparam int LSB_STAT_R = 8;
    // ****************************************************************
    // Codes and reset values
    // ****************************************************************
    localparam logic [7:0] GAIN_ZERO_DB = 8'hC0;
    localparam logic [7:0] GAIN_MUTE = 8'h00;
    localparam logic [7:0] GAIN_RESET = 8'hC0;
    localparam logic [3:0] SIDE_UNITY = 4'hC;
    localparam logic [3:0] SIDE_RESET = 4'h0;
    localparam logic [1:0] MIX_NONE = 2'h0;
    localparam logic [1:0] MIX_ADC_L = 2'h1;
    localparam logic [1:0] MIX_ADC_R = 2'h2;
    localparam logic [1:0] MIX_RESET = 2'h0;
    localparam logic EN_RESET = 1'b0;
endpackage
`default_nettype wire

// *** core/dvsg_top.sv ***
// Playback gain, channel enables and sidetone mix with a Wishbone slave.
// Assumes samples and ADC filter samples come from logic on clk_i.
//
// Design decision made here: the Wishbone interface to the registers.
`default_nettype none
module dvsg_top #(
    parameter int W = 24
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [9:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic sample_valid_i,
    input wire logic signed [W-1:0] pcm_left_i,
    input wire logic signed [W-1:0] pcm_right_i,
    input wire logic signed [W-1:0] adc_hpf_left_i,
    input wire logic signed [W-1:0] adc_hpf_right_i,
    output logic out_valid_o,
    output logic signed [W-1:0] out_left_o,
    output logic signed [W-1:0] out_right_o,
    output logic left_playback_enable_o,
    output logic right_playback_enable_o
);
    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic ack;
        logic [31:0] dat;
        logic left_playback_enable;
        logic right_playback_enable;
        logic [7:0] left_playback_gain;
        logic [7:0] right_playback_gain;
        logic [7:0] app_l;
        logic [7:0] app_r;
        logic [3:0] left_sidetone_gain;
        logic [3:0] right_sidetone_gain;
        logic [1:0] mix_l;
        logic [1:0] mix_r;
        logic out_valid;
        logic signed [W-1:0] out_l;
        logic signed [W-1:0] out_r;
    } dvsg_state_s;

    dvsg_state_s s_r;
    dvsg_state_s s_nxt;

    // ****************************************************************
    // Gain decoding
    // ****************************************************************
    function automatic logic [7:0] vol_atten(input logic [7:0] code);
        if (code >= dvsg_pkg::GAIN_ZERO_DB) begin
            vol_atten = 8'h00; // R10
        end else begin
            vol_atten = dvsg_pkg::GAIN_ZERO_DB - code; // R06 R07
        end
    endfunction

    // 3 dB is eight 0.375 dB steps, so one table serves both paths
    function automatic logic [7:0] side_atten(input logic [3:0] code);
        logic [3:0] d;
        d = dvsg_pkg::SIDE_UNITY - code;
        if (code >= dvsg_pkg::SIDE_UNITY) begin
            side_atten = 8'h00; // R01
        end else begin
            side_atten = {1'b0, d, 3'b000}; // R01
        end
    endfunction

    function automatic logic signed [W-1:0] sat_add(
        input logic signed [W-1:0] a, input logic signed [W-1:0] b);
        logic signed [W:0] sum;
        sum = {a[W-1], a} + {b[W-1], b};
        if (sum[W] != sum[W-1]) begin
            sat_add = sum[W] ? {1'b1, {(W-1){1'b0}}} : {1'b0, {(W-1){1'b1}}};
        end else begin
            sat_add = sum[W-1:0];
        end
    endfunction

    // ****************************************************************
    // Audio path
    // ****************************************************************
    logic signed [W-1:0] pcm_g_l;
    logic signed [W-1:0] pcm_g_r;
    logic signed [W-1:0] side_src_l;
    logic signed [W-1:0] side_src_r;
    logic signed [W-1:0] side_g_l;
    logic signed [W-1:0] side_g_r;

    // Sidetone taken after the ADC high-pass filter, before scaling
    assign side_src_l = (s_r.mix_l == dvsg_pkg::MIX_ADC_R) ?
        adc_hpf_right_i : adc_hpf_left_i; // R09
    assign side_src_r = (s_r.mix_r == dvsg_pkg::MIX_ADC_R) ?
        adc_hpf_right_i : adc_hpf_left_i; // R09

    dvsg_gain #(.W(W)) u_pcm_l (
        .sample_i(pcm_left_i),
        .atten_i(vol_atten(s_r.app_l)),
        .mute_i(s_r.app_l == dvsg_pkg::GAIN_MUTE), // R05
        .sample_o(pcm_g_l)
    );
    dvsg_gain #(.W(W)) u_pcm_r (
        .sample_i(pcm_right_i),
        .atten_i(vol_atten(s_r.app_r)),
        .mute_i(s_r.app_r == dvsg_pkg::GAIN_MUTE), // R05
        .sample_o(pcm_g_r)
    );
    dvsg_gain #(.W(W)) u_side_l (
        .sample_i(side_src_l),
        .atten_i(side_atten(s_r.left_sidetone_gain)),
        .mute_i(s_r.mix_l == dvsg_pkg::MIX_NONE || s_r.mix_l == 2'h3),
        .sample_o(side_g_l)
    );
    dvsg_gain #(.W(W)) u_side_r (
        .sample_i(side_src_r),
        .atten_i(side_atten(s_r.right_sidetone_gain)),
        .mute_i(s_r.mix_r == dvsg_pkg::MIX_NONE || s_r.mix_r == 2'h3),
        .sample_o(side_g_r)
    );

    // ****************************************************************
    // Bus and next state
    // ****************************************************************
    logic [7:0] idx;
    logic take;
    logic wr;
    logic upd;
    logic [31:0] rd;

    assign idx = wb_adr_i[9:2];
    assign take = wb_cyc_i && wb_stb_i && !s_r.ack;
    assign wr = take && wb_we_i;
    assign upd = wr && wb_sel_i[1] && wb_dat_i[dvsg_pkg::BIT_UPDATE] &&
        (idx == dvsg_pkg::IDX_GAIN_L || idx == dvsg_pkg::IDX_GAIN_R); // R04

    always_comb begin
        rd = 32'h0000_0000;
        case (idx)
            dvsg_pkg::IDX_POWER: begin
                rd[dvsg_pkg::BIT_EN_L] = s_r.left_playback_enable; // R02
                rd[dvsg_pkg::BIT_EN_R] = s_r.right_playback_enable;
            end
            dvsg_pkg::IDX_GAIN_L: begin
                rd[dvsg_pkg::BIT_GAIN_EN] = s_r.left_playback_enable; // R03
                rd[7:0] = s_r.left_playback_gain;
            end
            dvsg_pkg::IDX_GAIN_R: begin
                rd[dvsg_pkg::BIT_GAIN_EN] = s_r.right_playback_enable; // R03
                rd[7:0] = s_r.right_playback_gain;
            end
            dvsg_pkg::IDX_SIDE_MIX: begin
                rd[dvsg_pkg::LSB_MIX_L+:2] = s_r.mix_l;
                rd[dvsg_pkg::LSB_MIX_R+:2] = s_r.mix_r;
            end
            dvsg_pkg::IDX_SIDE_GAIN: begin
                rd[dvsg_pkg::LSB_SIDE_L+:4] = s_r.left_sidetone_gain;
                rd[dvsg_pkg::LSB_SIDE_R+:4] = s_r.right_sidetone_gain;
            end
            dvsg_pkg::IDX_STATUS: begin
                rd[7:0] = s_r.app_l;
                rd[dvsg_pkg::LSB_STAT_R+:8] = s_r.app_r;
            end
            default: rd = 32'h0000_0000;
        endcase
    end

    always_comb begin
        s_nxt = s_r;
        s_nxt.ack = take;
        if (take) begin
            s_nxt.dat = wb_we_i ? 32'h0000_0000 : rd;
        end
        // Both enable locations write one storage bit
        if (wr && wb_sel_i[0] && idx == dvsg_pkg::IDX_POWER) begin
            s_nxt.left_playback_enable = wb_dat_i[dvsg_pkg::BIT_EN_L]; // R02
            s_nxt.right_playback_enable = wb_dat_i[dvsg_pkg::BIT_EN_R];
        end
        if (wr && wb_sel_i[1] && idx == dvsg_pkg::IDX_GAIN_L) begin
            s_nxt.left_playback_enable =
                wb_dat_i[dvsg_pkg::BIT_GAIN_EN]; // R03
        end
        if (wr && wb_sel_i[1] && idx == dvsg_pkg::IDX_GAIN_R) begin
            s_nxt.right_playback_enable =
                wb_dat_i[dvsg_pkg::BIT_GAIN_EN]; // R03
        end
        if (wr && wb_sel_i[0] && idx == dvsg_pkg::IDX_GAIN_L) begin
            s_nxt.left_playback_gain = wb_dat_i[7:0]; // R06
        end
        if (wr && wb_sel_i[0] && idx == dvsg_pkg::IDX_GAIN_R) begin
            s_nxt.right_playback_gain = wb_dat_i[7:0]; // R07
        end
        if (wr && wb_sel_i[1] && idx == dvsg_pkg::IDX_SIDE_MIX) begin
            s_nxt.mix_l = wb_dat_i[dvsg_pkg::LSB_MIX_L+:2];
            s_nxt.mix_r = wb_dat_i[dvsg_pkg::LSB_MIX_R+:2];
        end
        if (wr && idx == dvsg_pkg::IDX_SIDE_GAIN) begin
            if (wb_sel_i[1]) begin
                s_nxt.left_sidetone_gain = wb_dat_i[dvsg_pkg::LSB_SIDE_L+:4];
            end
            if (wb_sel_i[0]) begin
                s_nxt.right_sidetone_gain = wb_dat_i[dvsg_pkg::LSB_SIDE_R+:4];
            end
        end
        // Applied pair moves together, including this same write
        if (upd) begin
            s_nxt.app_l = s_nxt.left_playback_gain; // R04
            s_nxt.app_r = s_nxt.right_playback_gain; // R04
        end
        // Paced only by the sample strobe, so any rate works
        s_nxt.out_valid = sample_valid_i; // R08
        if (sample_valid_i) begin
            s_nxt.out_l = s_r.left_playback_enable ?
                sat_add(pcm_g_l, side_g_l) : '0; // R02
            s_nxt.out_r = s_r.right_playback_enable ?
                sat_add(pcm_g_r, side_g_r) : '0; // R02
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_r <= '0;
            s_r.left_playback_enable <= dvsg_pkg::EN_RESET; // R02
            s_r.right_playback_enable <= dvsg_pkg::EN_RESET;
            s_r.left_playback_gain <= dvsg_pkg::GAIN_RESET; // R06
            s_r.right_playback_gain <= dvsg_pkg::GAIN_RESET; // R07
            s_r.app_l <= dvsg_pkg::GAIN_RESET;
            s_r.app_r <= dvsg_pkg::GAIN_RESET;
            s_r.left_sidetone_gain <= dvsg_pkg::SIDE_RESET;
            s_r.right_sidetone_gain <= dvsg_pkg::SIDE_RESET;
            s_r.mix_l <= dvsg_pkg::MIX_RESET;
            s_r.mix_r <= dvsg_pkg::MIX_RESET;
        end else if (ce_i) begin
            s_r <= s_nxt;
        end
    end

    assign wb_ack_o = s_r.ack;
    assign wb_dat_o = s_r.dat;
    assign out_valid_o = s_r.out_valid;
    assign out_left_o = s_r.out_l;
    assign out_right_o = s_r.out_r;
    assign left_playback_enable_o = s_r.left_playback_enable;
    assign right_playback_enable_o = s_r.right_playback_enable;

    // ****************************************************************
    // Checks
    // ****************************************************************
    a_enable_reset: assert property (@(posedge clk_i) // R02
        disable iff (rst_i)
        $past(rst_i) |-> !s_r.left_playback_enable &&
            !s_r.right_playback_enable)
        else $error("enables not zero after reset");
    a_gain_reset: assert property (@(posedge clk_i) disable iff (rst_i) // R06
        $past(rst_i) |-> s_r.app_l == dvsg_pkg::GAIN_RESET &&
            s_r.app_r == dvsg_pkg::GAIN_RESET)
        else $error("gain not 0 dB after reset");
    a_power_write: assert property (@(posedge clk_i) disable iff (rst_i) // R02
        ce_i && wr && wb_sel_i[0] && idx == dvsg_pkg::IDX_POWER |=>
            left_playback_enable_o == $past(wb_dat_i[4]) &&
            right_playback_enable_o == $past(wb_dat_i[5]))
        else $error("power enable write lost");
    a_enable_alias: assert property (@(posedge clk_i) // R03
        disable iff (rst_i)
        ce_i && wr && wb_sel_i[1] && idx == dvsg_pkg::IDX_GAIN_R |=>
            right_playback_enable_o == $past(wb_dat_i[15]))
        else $error("enable alias write lost");
    a_gain_held: assert property (@(posedge clk_i) disable iff (rst_i) // R04
        !(ce_i && upd) |=> $stable(s_r.app_l) && $stable(s_r.app_r))
        else $error("gain applied without update");
    a_gain_update: assert property (@(posedge clk_i) disable iff (rst_i) // R04
        ce_i && upd |=> s_r.app_l == s_r.left_playback_gain &&
            s_r.app_r == s_r.right_playback_gain)
        else $error("update did not apply gains");
    a_mute_zero: assert property (@(posedge clk_i) disable iff (rst_i) // R05
        ce_i && sample_valid_i && s_r.app_l == 8'h00 &&
            s_r.mix_l == 2'h0 |=> out_left_o == '0)
        else $error("muted channel not zero");
    a_unity_gain: assert property (@(posedge clk_i) disable iff (rst_i) // R10
        ce_i && sample_valid_i && s_r.left_playback_enable &&
            s_r.app_l >= 8'hC0 && s_r.mix_l == 2'h0 |=>
            out_left_o == $past(pcm_left_i))
        else $error("0 dB code did not pass sample");
    a_side_unity: assert property (@(posedge clk_i) disable iff (rst_i) // R01
        ce_i && sample_valid_i && s_r.right_playback_enable &&
            s_r.app_r == 8'h00 && s_r.mix_r == 2'h1 &&
            s_r.right_sidetone_gain >= 4'hC |=>
            out_right_o == $past(adc_hpf_left_i))
        else $error("sidetone 0 dB not unity");
    a_disabled_zero: assert property (@(posedge clk_i) // R02
        disable iff (rst_i)
        ce_i && sample_valid_i && !s_r.right_playback_enable |=>
            out_right_o == '0)
        else $error("disabled channel not zero");
    c_update: cover property (@(posedge clk_i) disable iff (rst_i)
        ce_i && upd);
    c_sidetone: cover property (@(posedge clk_i) disable iff (rst_i)
        ce_i && sample_valid_i && s_r.mix_l == 2'h2);
    c_read_status: cover property (@(posedge clk_i) disable iff (rst_i)
        take && !wb_we_i && idx == dvsg_pkg::IDX_STATUS);
endmodule
`default_nettype wire

// *** test/dvsg_src.sv ***
// Sample source standing in for the serial audio interface.
// Assumes the block's clock; one valid pulse every period_i cycles.
`default_nettype none
module dvsg_src (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic run_i,
    input wire logic [15:0] period_i,
    output logic valid_o,
    output logic signed [23:0] left_o,
    output logic signed [23:0] right_o,
    output logic signed [23:0] adcl_o,
    output logic signed [23:0] adcr_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [31:0] rnd_r;
    logic [15:0] cnt_r;
    // ************************************************************
    // Frame timing
    // ************************************************************
    always @(posedge clk_i) begin
        valid_o <= 1'b0;
        // Stale data toggles every cycle so it can never pass as valid
        left_o <= ~left_o;
        right_o <= ~right_o;
        adcl_o <= ~adcl_o;
        adcr_o <= ~adcr_o;
        if (rst_i) begin
            cnt_r <= 16'h0000;
            rnd_r <= 32'h00000008;
            {left_o, right_o, adcl_o, adcr_o} <= 96'h0;
        end else if (run_i && cnt_r + 16'h0001 >= period_i) begin
            cnt_r <= 16'h0000;
            rnd_r <= {rnd_r[30:0], 1'b0} ^
                (rnd_r[31] ? 32'h04C11DB7 : 32'h00000000);
            valid_o <= 1'b1;
            left_o <= rnd_r[23:0];
            right_o <= rnd_r[31:8];
            adcl_o <= {rnd_r[11:0], rnd_r[23:12]};
            adcr_o <= ~rnd_r[27:4];
        end else if (run_i) begin
            cnt_r <= cnt_r + 16'h0001;
        end
    end
endmodule
`default_nettype wire

// *** test/tb.sv ***
// Self-checking bench for the playback gain block.
// Assumes dvsg_pkg, dvsg_top and the dvsg_src sample source.
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic ce_i = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, run = 1'b0;
    logic [9:0] adr = 10'h000;
    logic [3:0] sel = 4'h0;
    logic [31:0] dat = 32'h0, wb_dat_o;
    logic [15:0] period = 16'h0014, lf = 16'h0008;
    logic wb_ack_o, sample_valid_i, out_valid_o, vld_q = 1'b0;
    logic left_en_o, right_en_o;
    logic signed [23:0] pl, pr, al, ar, out_left_o, out_right_o;
    logic [1:0] m_en = 2'b00, m_ml = 2'h0, m_mr = 2'h0;
    logic [7:0] m_gl = 8'hC0, m_gr = 8'hC0;
    logic [3:0] m_sl = 4'h0, m_sr = 4'h0;
    logic [7:0] tab [8] = '{8'h00, 8'h01, 8'h10, 8'h60, 8'hB0, 8'hBF,
                            8'hC0, 8'hFF};
    int n_errors = 0, total_checks = 0, n_out = 0;
    int e_l, e_r, t_l, t_r;
    always #10 clk_i = ~clk_i;
    dvsg_src src_u (.clk_i(clk_i), .rst_i(rst_i), .run_i(run),
        .period_i(period), .valid_o(sample_valid_i), .left_o(pl),
        .right_o(pr), .adcl_o(al), .adcr_o(ar));
    dvsg_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .sample_valid_i(sample_valid_i),
        .pcm_left_i(pl), .pcm_right_i(pr), .adc_hpf_left_i(al),
        .adc_hpf_right_i(ar), .out_valid_o(out_valid_o),
        .out_left_o(out_left_o), .out_right_o(out_right_o),
        .left_playback_enable_o(left_en_o),
        .right_playback_enable_o(right_en_o));
    // ************************************************************
    // Expectation and comparison
    // ************************************************************
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic real pgain(input logic [7:0] c);
        if (c == 8'h00) return 0.0;
        if (c >= 8'hC0) return 1.0;
        return 10.0 ** (-0.375 * (8'hC0 - c) / 20.0);
    endfunction
    function automatic real sgain(input logic [3:0] c);
        return (c >= 4'hC) ? 1.0 : 10.0 ** (-3.0 * (12 - c) / 20.0);
    endfunction
    // Non-unity gains are approximated in hardware, hence the margin
    task automatic calc(input logic signed [23:0] p, input logic signed
        [23:0] s, input logic en, input logic [7:0] g, input logic [3:0] c,
        output int e, output int t);
        real a, b, r;
        a = p * pgain(g);
        b = s * sgain(c);
        r = a + b;
        if (r > 8388607.0) r = 8388607.0;
        if (r < -8388608.0) r = -8388608.0;
        e = en ? int'(r) : 0;
        t = (!en || ((g == 8'h00 || g >= 8'hC0) && (s == 0 || c >= 4'hC)))
            ? 0 : int'(0.04 * ((a < 0 ? -a : a) + (b < 0 ? -b : b))) + 4;
    endtask
    function automatic logic signed [23:0] pick(input logic [1:0] m);
        return (m == 2'h1) ? al : (m == 2'h2) ? ar : 24'sh0;
    endfunction
    task automatic check(input logic [31:0] s, input logic [31:0] e,
        input int t);
        int d;
        total_checks++;
        d = int'(s) - int'(e);
        if ((^s === 1'bx) || (s !== e && (d > t || d < -t))) begin
            n_errors++;
            $display("Error at %0t: saw %h, expected %h", $time, s, e);
        end
    endtask
    always @(posedge clk_i) begin
        if (!rst_i) begin
            if (out_valid_o === 1'b1) begin
                check({{8{out_left_o[23]}}, out_left_o}, e_l, t_l);
                check({{8{out_right_o[23]}}, out_right_o}, e_r, t_r);
                n_out++;
            end
            check({31'h0, out_valid_o}, {31'h0, vld_q}, 0);
        end
        vld_q = sample_valid_i && !rst_i;
        if (sample_valid_i) begin
            calc(pl, pick(m_ml), m_en[0], m_gl, m_sl, e_l, t_l);
            calc(pr, pick(m_mr), m_en[1], m_gr, m_sr, e_r, t_r);
        end
    end
    // ************************************************************
    // Bus and stream tasks
    // ************************************************************
    task automatic wb(input logic w, input logic [7:0] i,
        input logic [15:0] d, input logic [3:0] s, output logic [31:0] q);
        @(posedge clk_i);
        // Previous ack must be gone: one pulse per request
        check({31'h0, wb_ack_o}, 32'h0, 0);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {i, 2'b00};
        sel <= s;
        dat <= {16'h0000, d};
        // No cycle count assumed; only the watchdog ends a hang
        do begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] i, input logic [15:0] d,
        input logic [3:0] s);
        logic [31:0] q;
        wb(1'b1, i, d, s, q);
    endtask
    task automatic rd(input logic [7:0] i, input logic [15:0] e);
        logic [31:0] q;
        wb(1'b0, i, 16'h0000, 4'hF, q);
        check(q, {16'h0000, e}, 0);
    endtask
    task automatic cfg(input logic [1:0] e, input logic [7:0] a, b,
        input logic [3:0] x, y, input logic [1:0] m, n);
        wr(dvsg_pkg::IDX_POWER, {10'h000, e, 4'h0}, 4'h1);
        wr(dvsg_pkg::IDX_SIDE_GAIN, {4'h0, x, y, 4'h0}, 4'h3);
        wr(dvsg_pkg::IDX_SIDE_MIX, {2'h0, m, n, 10'h000}, 4'h3);
        wr(dvsg_pkg::IDX_GAIN_L, {e[0], 7'h00, a}, 4'h1);
        wr(dvsg_pkg::IDX_GAIN_R, {e[1], 7'h01, b}, 4'h3);
        {m_en, m_gl, m_gr, m_sl, m_sr, m_ml, m_mr} = {e, a, b, x, y, m, n};
    endtask
    task automatic play(input int p, input int n);
        int k;
        period <= p[15:0];
        run <= 1'b1;
        n_out = 0;
        k = 0;
        while (n_out < n && k < n * p + 50) begin
            @(posedge clk_i);
            k++;
        end
        run <= 1'b0;
        repeat (3) @(posedge clk_i);
        if (n_out < n) check(n_out, n, 0);
    endtask
    task automatic final_report;
        $display("Checks %0d, errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // ************************************************************
    // Tests
    // ************************************************************
    initial begin
        #2_000_000;
        $display("Error at %0t: watchdog expired", $time);
        n_errors++;
        final_report();
    end
    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(dvsg_pkg::IDX_POWER, 16'h0000);
        rd(dvsg_pkg::IDX_GAIN_L, 16'h00C0);
        rd(dvsg_pkg::IDX_GAIN_R, 16'h00C0);
        rd(dvsg_pkg::IDX_STATUS, 16'hC0C0);
        $display("reset values done");
        wr(dvsg_pkg::IDX_POWER, 16'h0030, 4'h1);
        rd(dvsg_pkg::IDX_GAIN_L, 16'h80C0);
        check({30'h0, left_en_o, right_en_o}, 32'h3, 0);
        wr(dvsg_pkg::IDX_GAIN_R, 16'h00C0, 4'h2);
        rd(dvsg_pkg::IDX_POWER, 16'h0010);
        check({30'h0, left_en_o, right_en_o}, 32'h2, 0);
        $display("enable alias done");
        wr(dvsg_pkg::IDX_GAIN_L, 16'h0060, 4'h1);
        wr(dvsg_pkg::IDX_GAIN_R, 16'h0025, 4'h1);
        rd(dvsg_pkg::IDX_STATUS, 16'hC0C0);
        wr(dvsg_pkg::IDX_GAIN_L, 16'h8100, 4'h2);
        rd(dvsg_pkg::IDX_STATUS, 16'h2560);
        rd(dvsg_pkg::IDX_GAIN_L, 16'h8060);
        for (int i = 0; i < 8; i++) begin
            lf = lfsr(lf);
            wr(dvsg_pkg::IDX_GAIN_R, {8'h01, lf[7:0]}, 4'h3);
            rd(dvsg_pkg::IDX_STATUS, {lf[7:0], 8'h60});
        end
        wr(8'h10, 16'hFFFF, 4'h3);
        rd(8'h10, 16'h0000);
        $display("update strobe done");
        // Frozen block must neither answer nor store
        ce_i <= 1'b0;
        fork
            wr(dvsg_pkg::IDX_POWER, 16'h0000, 4'h1);
            begin
                repeat (4) @(posedge clk_i);
                check({30'h0, left_en_o, wb_ack_o}, 32'h2, 0);
                ce_i <= 1'b1;
            end
        join
        check({30'h0, left_en_o, right_en_o}, 32'h0, 0);
        $display("clock enable done");
        for (int i = 0; i < 16; i++) begin
            lf = lfsr(lf);
            cfg((i == 3) ? 2'b01 : 2'b11, tab[i % 8], lf[7:0], i[3:0],
                ~i[3:0], i[1:0], i[2:1]);
            play(20, 6);
        end
        // Corner: top code unity, muted right carries unity sidetone
        cfg(2'b11, 8'hFF, 8'h00, 4'h0, 4'hD, 2'h0, 2'h1);
        play(20, 4);
        $display("gain and sidetone done");
        cfg(2'b11, 8'h90, 8'hC0, 4'hC, 4'h5, 2'h1, 2'h2);
        play(1042, 3);
        play(6250, 2);
        $display("sample rates done");
        final_report();
    end
endmodule
`default_nettype wire
